/* File: eif_pkg.sv */
package eif_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INTR_ENABLE = 8'h08;
    localparam logic [7:0] OFS_FRAME_INDEX = 8'h0c;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    // status and enable bit positions
    localparam int BIT_XFER_DONE = 0;
    localparam int BIT_XACT_ERR = 1;
    localparam int BIT_PORT_CHG = 2;
    localparam int BIT_ROLLOVER = 3;
    localparam int BIT_SYS_ERR = 4;
    localparam int BIT_ASYNC_ADV = 5;
    localparam int NUM_SRC = 6;
    // command register fields
    localparam int CMD_RUN_BIT = 0;
    localparam int CMD_FLS_LSB = 2;
    localparam int CMD_THR_LSB = 16;
    // reset values
    localparam logic [5:0] RST_ENABLE = 6'h00;
    localparam logic [13:0] RST_FRAME_INDEX = 14'h0000;
    localparam logic [7:0] RST_THRESHOLD = 8'h08;
    localparam logic [1:0] RST_FLS = 2'h0;
    // sources held back until a threshold boundary
    localparam logic [5:0] THR_GATED_MASK = 6'h23;
    // micro-frame period
    localparam int UFRAME_NS = 125000;
    localparam int CLK_NS = 10;
    localparam int UFRAME_CYCLES = UFRAME_NS / CLK_NS;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: eif_sof_rx.sv */
`timescale 1ns/1ps
// bus side: takes each sof token and keeps its frame number
module eif_sof_rx
    import eif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sof_strobe,
    input wire logic [10:0] sof_shadow_count,
    output logic [10:0] frame_ff,
    output int count_ff
);
    // number only valid at the strobe, so sample nothing else
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            frame_ff <= 11'h000;
            count_ff <= 0;
        end
        else if (sof_strobe)
        begin
            frame_ff <= sof_shadow_count;
            count_ff <= count_ff + 1;
        end
    end
endmodule

/* File: eif_thresh.sv */
`timescale 1ns/1ps
// marks the interrupt threshold boundary every thr micro-frames
module eif_thresh
    import eif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic uframe_tick,
    input wire logic [7:0] thr,
    output logic boundary
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic bnd_ff;
    logic nxt_bnd;

    // zero threshold treated as one micro-frame
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_bnd = 1'b0;
        if (uframe_tick)
        begin
            if (cnt_ff + 8'h01 >= thr)
            begin
                nxt_cnt = 8'h00;
                nxt_bnd = 1'b1;
            end
            else
                nxt_cnt = cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= 8'h00;
            bnd_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            bnd_ff <= nxt_bnd;
        end
    end

    assign boundary = bnd_ff;
endmodule

/* File: eif_top.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - async-advance flag with enable 5 interrupts at next threshold boundary
// - host-system-error flag with enable 4 interrupts immediately
// - frame-list-rollover flag with enable 3 interrupts
// - port-change flag with enable 2 interrupts
// - transaction-error flag with enable 1 interrupts at next threshold boundary
// - transfer-complete flag with enable 0 interrupts at next threshold boundary
// - enable bits read and write; one enables, zero disables
// - frame index increments by one each micro-frame end
// - frame index bits N..3 give the frame-list index
// - list size code selects N: 12, 11, 10; code 11 reserved
// - sof frame number from counter, running one micro-frame ahead
// - 11-bit sof shadow advances when low index bits go 0 to 1
// - reset and index writes copy bits 13..3 into shadow
// - rollover flag set on wrap of the frame-list index
module eif_top
    import eif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ev_async_adv,
    input wire logic ev_sys_err,
    input wire logic ev_port_chg,
    input wire logic ev_xact_err,
    input wire logic ev_xfer_done,
    output logic irq,
    output logic [9:0] list_index,
    output logic [10:0] sof_shadow_count,
    output logic sof_strobe
);
    // frame-list index width per size code; reserved code falls back to 1024
    function automatic logic [9:0] list_idx(input logic [13:0] fi, input logic [1:0] fls);
        unique case (fls)
            2'h1: list_idx = {1'b0, fi[11:3]};
            2'h2: list_idx = {2'b00, fi[10:3]};
            default: list_idx = fi[12:3];
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                merge[i*8 +: 8] = wd[i*8 +: 8];
    endfunction

    // register state
    logic [5:0] enable_ff, nxt_enable;
    logic [5:0] status_ff, nxt_status;
    logic [5:0] pending_ff, nxt_pending;
    logic [13:0] findex_ff, nxt_findex;
    logic [10:0] sof_shadow_count_ff, nxt_sof_shadow_count;
    logic run_ff, nxt_run;
    logic [1:0] fls_ff, nxt_fls;
    logic [7:0] thr_ff, nxt_thr;
    logic irq_ff, nxt_irq;
    logic [9:0] lidx_ff, nxt_lidx;
    logic sof_ff, nxt_sof;
    logic init_ff;
    // bus state
    logic aw_ff, nxt_aw, w_ff, nxt_w;
    logic awready_ff, wready_ff;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic tick, boundary, wr_go;
    logic [5:0] events, wr_clear;
    logic [13:0] fi_next;
    logic [31:0] cmd_word;

    eif_uframe_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run_ff),
        .tick(tick)
    );

    eif_thresh u_thresh (
        .aclk(aclk),
        .aresetn(aresetn),
        .uframe_tick(tick),
        .thr(thr_ff),
        .boundary(boundary)
    );

    assign cmd_word = {8'h00, thr_ff, 12'h000, fls_ff, 1'b0, run_ff};

    // write channel: both address and data latched, in either order
    assign wr_go = aw_ff && w_ff && !bvalid_ff;

    always_comb
    begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && !aw_ff)
        begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff)
        begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            unique case (awaddr_ff)
                OFS_STATUS, OFS_INTR_ENABLE, OFS_FRAME_INDEX, OFS_COMMAND: nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready)
            nxt_bvalid = 1'b0;
    end

    // read channel: one-cycle ready, data from a register
    always_comb
    begin
        nxt_arready = 1'b0;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready)
            nxt_rvalid = 1'b0;
        // ready first; data one cycle after the address handshake, so rvalid never leads it
        if (s_axi_arvalid && !arready_ff && !rvalid_ff)
            nxt_arready = 1'b1;
        if (s_axi_arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_STATUS: nxt_rdata = {26'h0000000, status_ff};
                OFS_INTR_ENABLE: nxt_rdata = {26'h0000000, enable_ff};
                OFS_FRAME_INDEX: nxt_rdata = {18'h00000, findex_ff};
                OFS_COMMAND: nxt_rdata = cmd_word;
                default:
                begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    assign events = {ev_async_adv, ev_sys_err, 1'b0, ev_port_chg, ev_xact_err, ev_xfer_done};
    assign wr_clear = (wr_go && awaddr_ff == OFS_STATUS && wstrb_ff[0]) ? wdata_ff[5:0] : 6'h00;
    assign fi_next = findex_ff + 14'h0001;

    // core state: enables, status, frame index, shadow, interrupt
    always_comb
    begin
        logic [31:0] m;
        logic [5:0] raw;
        logic wrap;
        m = 32'h00000000;
        raw = events;
        wrap = 1'b0;
        nxt_enable = enable_ff;
        nxt_findex = findex_ff;
        nxt_sof_shadow_count = sof_shadow_count_ff;
        nxt_run = run_ff;
        nxt_fls = fls_ff;
        nxt_thr = thr_ff;
        if (wr_go && awaddr_ff == OFS_INTR_ENABLE)
        begin
            m = merge({26'h0000000, enable_ff}, wdata_ff, wstrb_ff);
            nxt_enable = m[5:0];
        end
        if (wr_go && awaddr_ff == OFS_COMMAND)
        begin
            m = merge(cmd_word, wdata_ff, wstrb_ff);
            nxt_run = m[CMD_RUN_BIT];
            nxt_fls = m[CMD_FLS_LSB +: 2];
            nxt_thr = m[CMD_THR_LSB +: 8];
        end
        if (wr_go && awaddr_ff == OFS_FRAME_INDEX)
        begin
            m = merge({18'h00000, findex_ff}, wdata_ff, wstrb_ff);
            nxt_findex = m[13:0];
            nxt_sof_shadow_count = m[13:3];
        end
        else if (tick)
        begin
            nxt_findex = fi_next;
            if (findex_ff[2:0] == 3'h0)
                nxt_sof_shadow_count = sof_shadow_count_ff + 11'h001;
            unique case (fls_ff)
                2'h1: wrap = findex_ff[11] && !fi_next[11];
                2'h2: wrap = findex_ff[10] && !fi_next[10];
                default: wrap = findex_ff[12] && !fi_next[12];
            endcase
        end
        raw[BIT_ROLLOVER] = wrap;
        // set beats the write-one clear
        nxt_status = (status_ff & ~wr_clear) | raw;
        // gated sources wait for a boundary; clearing the flag withdraws them
        nxt_pending = (pending_ff | (boundary ? (nxt_status & THR_GATED_MASK) : 6'h00)) & nxt_status;
        nxt_irq = |(nxt_enable & ((nxt_status & ~THR_GATED_MASK) | nxt_pending));
        nxt_lidx = list_idx(nxt_findex, nxt_fls);
        nxt_sof = tick;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
            enable_ff <= RST_ENABLE;
            status_ff <= 6'h00;
            pending_ff <= 6'h00;
            findex_ff <= RST_FRAME_INDEX;
            sof_shadow_count_ff <= RST_FRAME_INDEX[13:3];
            run_ff <= 1'b0;
            fls_ff <= RST_FLS;
            thr_ff <= RST_THRESHOLD;
            irq_ff <= 1'b0;
            lidx_ff <= 10'h000;
            sof_ff <= 1'b0;
        end
        else
        begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awready_ff <= !nxt_aw;
            wready_ff <= !nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            enable_ff <= nxt_enable;
            status_ff <= nxt_status;
            pending_ff <= nxt_pending;
            findex_ff <= nxt_findex;
            sof_shadow_count_ff <= nxt_sof_shadow_count;
            run_ff <= nxt_run;
            fls_ff <= nxt_fls;
            thr_ff <= nxt_thr;
            irq_ff <= nxt_irq;
            lidx_ff <= nxt_lidx;
            sof_ff <= nxt_sof;
        end
    end

    // ready stays low while a write is held so the master sees back-pressure
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign irq = irq_ff;
    assign list_index = lidx_ff;
    assign sof_shadow_count = sof_shadow_count_ff;
    assign sof_strobe = sof_ff;
endmodule

/* File: eif_top_properties.sv */
`timescale 1ns/1ps
// bus handshake and counter checks seen from the top pins
module eif_top_properties
    import eif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] list_index,
    input wire logic [10:0] sof_shadow_count,
    input wire logic sof_strobe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_rd_ans;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_ar_pulse;
        s_axi_arready |=> !s_axi_arready;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse)
        else $error("arready too long");
    property p_sof_pulse;
        sof_strobe |=> !sof_strobe [*8];
    endproperty
    a_sof_pulse: assert property (p_sof_pulse)
        else $error("sof strobe too long");
    // outside a register write the shadow only steps by one, next to a token
    property p_shadow_step;
        $changed(sof_shadow_count) && $past(aresetn) && !$rose(s_axi_bvalid)
            |-> (sof_shadow_count == $past(sof_shadow_count) + 11'h1) ##[0:1] sof_strobe;
    endproperty
    a_shadow_step: assert property (p_shadow_step)
        else $error("shadow moved wrongly");
    property p_index_step;
        $changed(list_index) && $past(aresetn) |-> $rose(s_axi_bvalid) or ##[0:1] sof_strobe;
    endproperty
    a_index_step: assert property (p_index_step)
        else $error("list index moved off frame");
endmodule

bind eif_top eif_top_properties u_eif_top_properties (.*);

/* File: eif_uframe_timer.sv */
`timescale 1ns/1ps
// one-cycle tick at the end of every micro-frame
module eif_uframe_timer
    import eif_pkg::*;
#(
    parameter int PERIOD = UFRAME_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic tick
);
    logic [16:0] cnt_ff;
    logic [16:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // count while running; restart cleanly when halted
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (!run)
            nxt_cnt = 17'h00000;
        else if (cnt_ff == 17'(PERIOD - 1))
        begin
            nxt_cnt = 17'h00000;
            nxt_tick = 1'b1;
        end
        else
            nxt_cnt = cnt_ff + 17'h00001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= 17'h00000;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

/* File: tb_eif_top.sv */
`timescale 1ns/1ps
`define chk(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_eif_top;
    import eif_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, sof_strobe;
    logic ev_async_adv, ev_sys_err, ev_port_chg, ev_xact_err, ev_xfer_done;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] list_index;
    logic [10:0] sof_shadow_count, rx_frame;
    int rx_count, miscompares, n_compared, n;
    eif_top u_eif_top (.*);
    eif_sof_rx u_eif_sof_rx (.aclk(aclk), .aresetn(aresetn), .sof_strobe(sof_strobe),
        .sof_shadow_count(sof_shadow_count), .frame_ff(rx_frame), .count_ff(rx_count));
    // 100 mhz
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic give_up(input int k, input int lim);
        if (k >= lim)
        begin
            miscompares++;
            $display("mismatch wait expected done seen timeout");
            final_report;
        end
    endtask
    // bready raised a cycle late so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end
        while (!(s_axi_bvalid && s_axi_bready) && k < 50);
        resp = s_axi_bresp;
        give_up(k, 50);
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
        end
        while (!(s_axi_rvalid && s_axi_rready) && k < 50);
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        give_up(k, 50);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
        rd(a);
        `chk(nm, ex, rd_data)
        `chk("rresp", RESP_OKAY, resp)
    endtask
    // one-cycle event pulses, status-bit ordered
    task automatic fire(input logic [5:0] v);
        {ev_async_adv, ev_sys_err, ev_port_chg, ev_xact_err, ev_xfer_done} <= {v[5:4], v[2:0]};
        @(posedge aclk);
        {ev_async_adv, ev_sys_err, ev_port_chg, ev_xact_err, ev_xfer_done} <= 5'h00;
        repeat (3) @(posedge aclk);
    endtask
    task automatic wait_sof(input int cnt);
        int k;
        for (k = 0; k < 30000 && rx_count < cnt; k++)
            @(posedge aclk);
        give_up(k, 30000);
        repeat (2) @(posedge aclk);
    endtask
    // main sequence
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {ev_async_adv, ev_sys_err, ev_port_chg, ev_xact_err, ev_xfer_done} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        miscompares = 0;
        n_compared = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(OFS_INTR_ENABLE, 32'h0, "enable reset");
        rchk(OFS_FRAME_INDEX, 32'h0, "index reset");
        `chk("shadow reset", 11'h000, sof_shadow_count)
        wr(OFS_INTR_ENABLE, 32'h0000003f);
        rchk(OFS_INTR_ENABLE, 32'h3f, "enable all");
        wr(OFS_INTR_ENABLE, 32'h00000014);
        // immediate sources, acked by write-one-to-clear
        for (int i = 2; i <= 4; i += 2)
        begin
            fire(6'h01 << i);
            `chk("irq set", 1'b1, irq)
            rchk(OFS_STATUS, 32'h1 << i, "status");
            wr(OFS_STATUS, 32'h1 << i);
            @(posedge aclk);
            `chk("irq clear", 1'b0, irq)
        end
        // an immediate source with its enable off must stay quiet
        wr(OFS_INTR_ENABLE, 32'h00000010);
        fire(6'h04);
        `chk("irq masked", 1'b0, irq)
        wr(OFS_STATUS, 32'h00000004);
        wr(8'h40, 32'h00000000);
        `chk("bresp unmapped", RESP_SLVERR, resp)
        rd(8'h40);
        `chk("rresp unmapped", RESP_SLVERR, resp)
        `chk("rdata unmapped", 32'h0, rd_data)
        wr(OFS_FRAME_INDEX, 32'h00003ffe);
        rchk(OFS_FRAME_INDEX, 32'h3ffe, "index");
        `chk("shadow load", 11'h7ff, sof_shadow_count)
        for (int s = 0; s < 3; s++)
        begin
            wr(OFS_COMMAND, 32'(s << CMD_FLS_LSB));
            @(posedge aclk);
            `chk("list index", 10'h3ff >> s, list_index)
        end
        // threshold of one micro-frame, run, gated sources wait for it
        wr(OFS_INTR_ENABLE, 32'h0000002b);
        wr(OFS_COMMAND, 32'h00010001);
        fire(6'h23);
        `chk("irq early", 1'b0, irq)
        for (n = 0; n < 13000 && irq !== 1'b1; n++)
            @(posedge aclk);
        give_up(n, 13000);
        wr(OFS_STATUS, 32'h00000023);
        @(posedge aclk);
        `chk("irq acked", 1'b0, irq)
        wait_sof(2);
        `chk("list wrap", 10'h000, list_index)
        `chk("sof token", 11'h7ff, rx_frame)
        `chk("irq rollover", 1'b1, irq)
        rchk(OFS_STATUS, 32'h08, "rollover");
        wr(OFS_STATUS, 32'h00000008);
        wait_sof(3);
        `chk("shadow step", 11'h000, sof_shadow_count)
        rchk(OFS_FRAME_INDEX, 32'h1, "index step");
        final_report;
    end
endmodule
